// ===== rtl/arop_buf2.sv
// two-entry result buffer with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module arop_buf2 #(parameter int W = 16)
(
    input  wire logic  clk,
    input  wire logic  rst,
    arop_stream_if.snk in_s,
    arop_stream_if.src out_s
);
    logic [W-1:0] mem [2];
    logic         wp;
    logic         rp;
    logic [1:0]   cnt;
    logic         next_wp;
    logic         next_rp;
    logic [1:0]   next_cnt;
    logic         push;
    logic         pop;

    assign in_s.ready  = (cnt != 2'h2);
    assign out_s.valid = (cnt != 2'h0);
    assign out_s.data  = mem[rp];

    always_comb
    begin
        push     = in_s.valid && in_s.ready;
        pop      = out_s.valid && out_s.ready;
        next_wp  = push ? ~wp : wp;
        next_rp  = pop ? ~rp : rp;
        next_cnt = cnt;
        if (push && !pop)
        begin
            next_cnt = cnt + 2'h1;
        end
        else if (pop && !push)
        begin
            next_cnt = cnt - 2'h1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wp  <= 1'b0;
            rp  <= 1'b0;
            cnt <= 2'h0;
        end
        else
        begin
            wp  <= next_wp;
            rp  <= next_rp;
            cnt <= next_cnt;
        end
        if (push)
        begin
            mem[wp] <= in_s.data;
        end
    end

    buf_bound_a: assert property (@(posedge clk) disable iff (rst) cnt <= 2'h2)
        else $error("buffer count beyond two");
endmodule
`default_nettype wire

// ===== rtl/arop_pkg.sv
// constants, types and helpers shared by the adc result output port
package arop_pkg;

    // ------------------------------------------------------------------
    // widths, counts and reset values
    // ------------------------------------------------------------------
    localparam int          AROP_W        = 16;
    localparam int          AROP_NCH      = 8;
    localparam logic [4:0]  AROP_SER_LAST = 5'h0f;
    localparam logic [15:0] AROP_WORD_RST = 16'h0000;
    localparam logic [15:0] AROP_OE_WORD  = 16'hffff;
    localparam logic [15:0] AROP_OE_BYTE  = 16'h00ff;
    localparam logic [15:0] AROP_OE_SER   = 16'h0180;
    localparam logic [15:0] AROP_OE_NONE  = 16'h0000;
    localparam int          AROP_MSB      = 15;
    localparam int          AROP_BMS_BIT  = 15;
    localparam int          AROP_HBF_BIT  = 14;
    localparam int          AROP_SOF_BIT  = 7;
    localparam int          AROP_SOS_BIT  = 8;

    // ------------------------------------------------------------------
    // modes and link states
    // ------------------------------------------------------------------
    typedef enum logic [2:0]
    {
        MODE_WORD = 3'b001,
        MODE_BYTE = 3'b010,
        MODE_SER  = 3'b100
    } arop_mode_t;

    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b001,
        ST_PAR  = 3'b010,
        ST_SER  = 3'b100
    } arop_state_t;

    function automatic arop_mode_t arop_mode(input logic strap, input logic bms);
        arop_mode_t m;
        m = MODE_WORD;
        if (strap)
        begin
            m = bms ? MODE_BYTE : MODE_SER;
        end
        return m;
    endfunction

endpackage

// ===== rtl/arop_stream_if.sv
// valid/ready word stream between the port's own modules
`timescale 1ns/100ps
`default_nettype none
interface arop_stream_if #(parameter int W = 16);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ===== rtl/arop_top.sv
// adc result output port: word, byte and serial read-out of results
`timescale 1ns/100ps
`default_nettype none
// Contract
// (RULE_01) With the strap low the result bus drives only while chip select and read are low.
// (RULE_02) In word mode bus pin n carries result bit n.
// (RULE_03) With the strap high, byte mode select 0 means serial and 1 means byte mode.
// (RULE_04) Byte mode delivers each result on the low eight pins over two strobes, bit 7 as MSB.
// (RULE_05) High byte first when the byte order input is 1, low byte first when it is 0.
// (RULE_06) In serial mode bit-7 pin is the first serial output and bit-8 pin the second.
// (RULE_07) The board ties unused bus pins low in strap-high modes, and byte order low in serial.
// (RULE_08) A high reference select enables the internal reference, a low one disables it.
// (RULE_09) Chip select falling presents the MSB serially and each clock rise shifts the next bit.
// (RULE_10) The first-channel flag rises when channel one is presented and clears on the next strobe or 16th clock fall.
// (RULE_11) The host finishes a read during busy before busy falls.
// (RULE_12) A reset during a read clears the output result registers to zero.
// (RULE_13) After each complete result the port moves to the next channel in ascending order.
module arop_top
    import arop_pkg::*;
#(
    parameter int NCH = AROP_NCH
)
(
    input  wire logic          MCLK,
    input  wire logic          SYS_RST,
    input  wire logic          LINK_CLK,
    input  wire logic          RES_VALID,
    input  wire logic [15:0]   RES_DATA,
    output logic               RES_READY,
    input  wire logic          CS_N,
    input  wire logic          RD_SCLK,
    input  wire logic          INTERFACE_SELECT_STRAP,
    input  wire logic [15:0]   RESULT_BUS_I,
    output logic      [15:0]   RESULT_BUS_O,
    output logic      [15:0]   RESULT_BUS_OE,
    output logic               FIRST_CHANNEL_FLAG_O,
    output logic               FIRST_CHANNEL_FLAG_OE,
    input  wire logic          REF_SELECT,
    output logic               INTERNAL_REF_ENABLE
);
    localparam int CHW = (NCH > 1) ? $clog2(NCH) : 1;

    function automatic logic [CHW-1:0] ch_step(input logic [CHW-1:0] c, input int s);
        return CHW'((int'(c) + s) % NCH);
    endfunction

    // ------------------------------------------------------------------
    // system side: buffer, word handshake, reference select
    // ------------------------------------------------------------------
    arop_stream_if #(.W(AROP_W)) in_s ();
    arop_stream_if #(.W(AROP_W)) out_s ();

    assign in_s.valid = RES_VALID;
    assign in_s.data  = RES_DATA;
    assign RES_READY  = in_s.ready;

    arop_buf2 #(.W(AROP_W)) u_buf
    (
        .clk   (MCLK),
        .rst   (SYS_RST),
        .in_s  (in_s),
        .out_s (out_s)
    );

    logic [15:0] xfer_data;
    logic        req;
    logic        ack_m1;
    logic        ack_m2;
    logic        ref_m1;
    logic        next_req;
    logic [15:0] next_xfer_data;
    logic        ack;

    // one word in flight; data held steady until the link acknowledges
    assign out_s.ready = (req == ack_m2);

    always_comb
    begin
        next_req       = req;
        next_xfer_data = xfer_data;
        if (out_s.valid && out_s.ready)
        begin
            next_req       = ~req;
            next_xfer_data = out_s.data;
        end
    end

    always_ff @(posedge MCLK)
    begin
        if (SYS_RST)
        begin
            req                 <= 1'b0;
            xfer_data           <= AROP_WORD_RST; // RULE_12
            ack_m1              <= 1'b0;
            ack_m2              <= 1'b0;
            ref_m1              <= 1'b0;
            INTERNAL_REF_ENABLE <= 1'b0;
        end
        else
        begin
            req                 <= next_req;
            xfer_data           <= next_xfer_data;
            ack_m1              <= ack;
            ack_m2              <= ack_m1;
            ref_m1              <= REF_SELECT;
            INTERNAL_REF_ENABLE <= ref_m1; // RULE_08
        end
    end

    // ------------------------------------------------------------------
    // link side: pin sampling and reset crossing
    // ------------------------------------------------------------------
    logic       lr1;
    logic       lrst;
    logic [5:0] s1;
    logic [5:0] s2;
    logic       cs_p;
    logic       rd_p;
    logic       cs_s;
    logic       rd_s;
    logic       strap_s;
    logic       bms_s;
    logic       hbf_s;
    logic       req_s;

    assign {req_s, hbf_s, bms_s, strap_s, rd_s, cs_s} = s2;

    always_ff @(posedge LINK_CLK)
    begin
        lr1  <= SYS_RST;
        lrst <= lr1;
        if (lrst)
        begin
            s1   <= 6'h03;
            s2   <= 6'h03;
            cs_p <= 1'b1;
            rd_p <= 1'b1;
        end
        else
        begin
            // RULE_07 bus bits 15/14 read as mode straps only when tied
            s1   <= {req, RESULT_BUS_I[AROP_HBF_BIT], RESULT_BUS_I[AROP_BMS_BIT],
                     INTERFACE_SELECT_STRAP, RD_SCLK, CS_N};
            s2   <= s1;
            cs_p <= cs_s;
            rd_p <= rd_s;
        end
    end

    // ------------------------------------------------------------------
    // link side: read-out state
    // ------------------------------------------------------------------
    arop_state_t    state;
    arop_state_t    next_state;
    arop_mode_t     mode;
    logic [15:0]    cur;
    logic [15:0]    sec;
    logic [15:0]    sh_a;
    logic [15:0]    sh_b;
    logic           cur_v;
    logic           sec_v;
    logic [CHW-1:0] ch;
    logic           byte_idx;
    logic [4:0]     bit_cnt;
    logic [15:0]    next_cur;
    logic [15:0]    next_sec;
    logic [15:0]    next_sh_a;
    logic [15:0]    next_sh_b;
    logic           next_cur_v;
    logic           next_sec_v;
    logic [CHW-1:0] next_ch;
    logic           next_byte_idx;
    logic [4:0]     next_bit_cnt;
    logic [15:0]    next_bus_o;
    logic [15:0]    next_bus_oe;
    logic           next_flag;
    logic           next_flag_oe;
    logic           next_ack;
    logic           cs_fall;
    logic           rd_fall;
    logic           rd_rise;
    logic           adv1;
    logic           adv2;
    logic           par_start;
    logic           par_end;

    always_comb
    begin
        mode          = arop_mode(strap_s, bms_s); // RULE_03
        cs_fall       = cs_p && !cs_s;
        rd_fall       = rd_p && !rd_s;
        rd_rise       = !rd_p && rd_s;
        adv1          = 1'b0;
        adv2          = 1'b0;
        par_start     = 1'b0;
        par_end       = 1'b0;
        next_state    = state;
        next_cur      = cur;
        next_sec      = sec;
        next_sh_a     = sh_a;
        next_sh_b     = sh_b;
        next_cur_v    = cur_v;
        next_sec_v    = sec_v;
        next_ch       = ch;
        next_byte_idx = byte_idx;
        next_bit_cnt  = bit_cnt;
        next_bus_o    = RESULT_BUS_O;
        next_flag     = FIRST_CHANNEL_FLAG_O;
        next_ack      = ack;
        case (state)
            ST_IDLE:
            begin
                if (cs_fall && mode == MODE_SER)
                begin
                    next_state   = ST_SER;
                    next_sh_a    = cur; // RULE_09
                    next_sh_b    = sec;
                    next_bit_cnt = 5'h00;
                    next_flag    = cur_v && ch == '0; // RULE_10
                end
                else if (cs_fall)
                begin
                    next_state = ST_PAR;
                    par_start  = !rd_s; // RULE_01
                end
            end
            ST_PAR:
            begin
                // select and strobe often move together, so a strobe spans both being low
                par_start = rd_fall && !cs_s;
                par_end   = !rd_p && (rd_s || cs_s);
                if (cs_s)
                begin
                    next_state = ST_IDLE;
                end
            end
            ST_SER:
            begin
                if (cs_s)
                begin
                    next_state = ST_IDLE;
                end
                else
                begin
                    if (rd_rise)
                    begin
                        next_sh_a = {sh_a[14:0], 1'b0}; // RULE_09
                        next_sh_b = {sh_b[14:0], 1'b0};
                    end
                    if (rd_fall)
                    begin
                        next_bit_cnt = bit_cnt + 5'h01;
                        if (bit_cnt == AROP_SER_LAST)
                        begin
                            next_flag    = 1'b0; // RULE_10
                            adv2         = 1'b1; // RULE_13
                            next_bit_cnt = 5'h00;
                        end
                    end
                end
            end
            default:
            begin
                next_state = ST_IDLE;
            end
        endcase
        if (par_start)
        begin
            next_flag = cur_v && ch == '0 && !byte_idx; // RULE_10
            if (mode == MODE_WORD)
            begin
                next_bus_o = cur; // RULE_02
            end
            else if (hbf_s ^ byte_idx)
            begin
                next_bus_o = {8'h00, cur[15:8]}; // RULE_04 RULE_05
            end
            else
            begin
                next_bus_o = {8'h00, cur[7:0]}; // RULE_05
            end
        end
        if (par_end)
        begin
            // a strobe only completes a word in byte mode on its second half
            adv1          = (mode == MODE_WORD) || byte_idx; // RULE_13
            next_byte_idx = (mode == MODE_BYTE) && !byte_idx;
        end
        if (next_state == ST_SER)
        begin
            next_bus_o = AROP_OE_NONE;
            next_bus_o[AROP_SOF_BIT] = next_sh_a[AROP_MSB]; // RULE_06
            next_bus_o[AROP_SOS_BIT] = next_sh_b[AROP_MSB];
        end
        if (adv1 && cur_v)
        begin
            next_cur   = sec;
            next_cur_v = sec_v;
            next_sec_v = 1'b0;
            next_ch    = ch_step(ch, 1); // RULE_13
        end
        else if (adv2 && cur_v)
        begin
            next_cur_v = 1'b0;
            next_sec_v = 1'b0;
            next_ch    = ch_step(ch, sec_v ? 2 : 1); // RULE_13
        end
        if (req_s != ack && !next_cur_v)
        begin
            next_cur   = xfer_data;
            next_cur_v = 1'b1;
            next_ack   = ~ack;
        end
        else if (req_s != ack && !next_sec_v)
        begin
            next_sec   = xfer_data;
            next_sec_v = 1'b1;
            next_ack   = ~ack;
        end
        next_flag_oe = !cs_s;
        next_bus_oe  = AROP_OE_NONE;
        if (!cs_s && mode == MODE_SER)
        begin
            next_bus_oe = AROP_OE_SER; // RULE_06
        end
        else if (!cs_s && !rd_s)
        begin
            next_bus_oe = (mode == MODE_WORD) ? AROP_OE_WORD : AROP_OE_BYTE; // RULE_01 RULE_04
        end
    end

    always_ff @(posedge LINK_CLK)
    begin
        if (lrst)
        begin
            state                 <= ST_IDLE;
            cur                   <= AROP_WORD_RST; // RULE_12
            sec                   <= AROP_WORD_RST;
            sh_a                  <= AROP_WORD_RST;
            sh_b                  <= AROP_WORD_RST;
            cur_v                 <= 1'b0;
            sec_v                 <= 1'b0;
            ch                    <= '0;
            byte_idx              <= 1'b0;
            bit_cnt               <= 5'h00;
            RESULT_BUS_O          <= AROP_WORD_RST;
            RESULT_BUS_OE         <= AROP_OE_NONE;
            FIRST_CHANNEL_FLAG_O  <= 1'b0;
            FIRST_CHANNEL_FLAG_OE <= 1'b0;
            ack                   <= 1'b0;
        end
        else
        begin
            state                 <= next_state;
            cur                   <= next_cur;
            sec                   <= next_sec;
            sh_a                  <= next_sh_a;
            sh_b                  <= next_sh_b;
            cur_v                 <= next_cur_v;
            sec_v                 <= next_sec_v;
            ch                    <= next_ch;
            byte_idx              <= next_byte_idx;
            bit_cnt               <= next_bit_cnt;
            RESULT_BUS_O          <= next_bus_o;
            RESULT_BUS_OE         <= next_bus_oe;
            FIRST_CHANNEL_FLAG_O  <= next_flag;
            FIRST_CHANNEL_FLAG_OE <= next_flag_oe;
            ack                   <= next_ack;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    word_oe_gate_a: assert property (@(posedge LINK_CLK) disable iff (lrst) // RULE_01
        (!$past(strap_s) && RESULT_BUS_OE != AROP_OE_NONE) |-> $past(!cs_s && !rd_s))
        else $error("bus driven outside a read strobe");
    word_bits_a: assert property (@(posedge LINK_CLK) disable iff (lrst) // RULE_02
        (par_start && mode == MODE_WORD) |=> RESULT_BUS_O == $past(cur))
        else $error("word read shows wrong result");
    mode_decode_a: assert property (@(posedge LINK_CLK) disable iff (lrst) // RULE_03
        (strap_s && !bms_s && !cs_s) |=> RESULT_BUS_OE == AROP_OE_SER || $past(lrst))
        else $error("serial mode not selected");
    byte_lanes_a: assert property (@(posedge LINK_CLK) disable iff (lrst) // RULE_04
        $past(mode == MODE_BYTE) |-> RESULT_BUS_OE[15:8] == 8'h00)
        else $error("byte mode drives upper lanes");
    byte_order_a: assert property (@(posedge LINK_CLK) disable iff (lrst) // RULE_05
        (par_start && mode == MODE_BYTE && !byte_idx)
        |=> RESULT_BUS_O[7:0] == ($past(hbf_s) ? $past(cur[15:8]) : $past(cur[7:0])))
        else $error("first byte out of order");
    serial_pins_a: assert property (@(posedge LINK_CLK) disable iff (lrst) // RULE_06
        (state == ST_SER) |-> (RESULT_BUS_O & ~AROP_OE_SER) == AROP_OE_NONE)
        else $error("serial mode drives other pins");
    ref_follow_a: assert property (@(posedge MCLK) disable iff (SYS_RST) // RULE_08
        !$past(SYS_RST, 2) |-> INTERNAL_REF_ENABLE == $past(REF_SELECT, 2))
        else $error("reference enable does not follow select");
    serial_msb_a: assert property (@(posedge LINK_CLK) disable iff (lrst) // RULE_09
        (state == ST_IDLE && cs_fall && mode == MODE_SER)
        |=> RESULT_BUS_O[AROP_SOF_BIT] == $past(cur[AROP_MSB]) ##1 state == ST_SER || cs_s)
        else $error("serial msb not presented");
    first_flag_a: assert property (@(posedge LINK_CLK) disable iff (lrst) // RULE_10
        (state == ST_SER && !cs_s && rd_fall && bit_cnt == AROP_SER_LAST) |=> !FIRST_CHANNEL_FLAG_O)
        else $error("first-channel flag not cleared");
    reset_clear_a: assert property (@(posedge LINK_CLK) // RULE_12
        $rose(lrst) |=> (cur == AROP_WORD_RST && RESULT_BUS_O == AROP_WORD_RST) [*2])
        else $error("result registers not cleared");
    channel_step_a: assert property (@(posedge LINK_CLK) disable iff (lrst) // RULE_13
        (adv1 && cur_v) |=> ch == ch_step($past(ch), 1))
        else $error("channel did not advance by one");

    word_read_c: cover property (@(posedge LINK_CLK) disable iff (lrst)
        state == ST_PAR && mode == MODE_WORD && adv1 && cur_v);
    byte_read_c: cover property (@(posedge LINK_CLK) disable iff (lrst)
        state == ST_PAR && mode == MODE_BYTE && adv1 && cur_v);
    serial_frame_c: cover property (@(posedge LINK_CLK) disable iff (lrst)
        adv2 && cur_v && sec_v);
endmodule
`default_nettype wire

// ===== verification/arop_host.sv
// host-side reader model: chip select, read strobe and serial clock
`timescale 1ns/100ps
`default_nettype none
module arop_host
(
    input  wire logic        link_clk,
    input  wire logic [15:0] bus_o,
    input  wire logic [15:0] bus_oe,
    input  wire logic        flag_o,
    output logic             cs_n,
    output logic             rd_sclk
);
    initial
    begin
        cs_n = 1'b1;
        rd_sclk = 1'b1;
    end
    task automatic waitl(input int n);
        repeat (n) @(negedge link_clk);
    endtask
    task automatic hold(input logic c, input logic r);
        cs_n = c;
        rd_sclk = r;
    endtask
    // pins are sampled, so every level lasts well over two link clocks
    task automatic strobe(output logic [15:0] d, output logic [15:0] oe, output logic f);
        hold(1'b0, 1'b0);
        waitl(6);
        d = bus_o & bus_oe;
        oe = bus_oe;
        f = flag_o;
        hold(1'b1, 1'b1);
        waitl(6);
    endtask
    // clock parks low before select falls so no stray edge is counted
    task automatic frame(output logic [15:0] a, output logic [15:0] b,
                         output logic [15:0] oe, output logic f, output logic fe);
        hold(1'b1, 1'b0);
        waitl(3);
        hold(1'b0, 1'b0);
        waitl(6);
        f = flag_o;
        oe = bus_oe;
        for (int i = 15; i >= 0; i--)
        begin
            a[i] = bus_o[7];
            b[i] = bus_o[8];
            rd_sclk = 1'b1;
            waitl(4);
            rd_sclk = 1'b0;
            waitl(4);
        end
        fe = flag_o;
        hold(1'b1, 1'b1);
        waitl(6);
    endtask
endmodule
`default_nettype wire

// ===== verification/arop_top_tb_top.sv
// self-checking bench for the adc result output port
`timescale 1ns/100ps
`default_nettype none
module arop_top_tb_top
    import arop_pkg::*;
;
    typedef struct
    {
        logic        strap, bms, hbf, rsel;
        logic [15:0] w0, w1, oe, e0, e1;
    } arop_row_t;
    logic        mclk, sys_rst, link_clk, res_valid, res_ready, strap, ref_sel, ire;
    logic        flag_o, flag_oe, cs_n, rd_sclk, f0, f1, ok, stall;
    logic [15:0] res_data, tie, bus_i, bus_o, bus_oe, a, b, oe, oe2;
    int          fails, checks, n;
    arop_row_t   r;
    arop_row_t   rows [4] = '{
        '{1'b0, 1'b0, 1'b0, 1'b1, 16'h1234, 16'habcd, 16'hffff, 16'h1234, 16'habcd},
        '{1'b1, 1'b1, 1'b1, 1'b0, 16'ha55a, 16'h0f0f, 16'h00ff, 16'h00a5, 16'h005a},
        '{1'b1, 1'b1, 1'b0, 1'b1, 16'hc381, 16'h7e11, 16'h00ff, 16'h0081, 16'h00c3},
        '{1'b1, 1'b0, 1'b0, 1'b0, 16'h8001, 16'h4cd2, 16'h0180, 16'h8001, 16'h4cd2}};
    // undriven pins read the board ties
    assign bus_i = (bus_o & bus_oe) | (tie & ~bus_oe);
    arop_top arop_top_inst
    (
        .MCLK                   (mclk),
        .SYS_RST                (sys_rst),
        .LINK_CLK               (link_clk),
        .RES_VALID              (res_valid),
        .RES_DATA               (res_data),
        .RES_READY              (res_ready),
        .CS_N                   (cs_n),
        .RD_SCLK                (rd_sclk),
        .INTERFACE_SELECT_STRAP (strap),
        .RESULT_BUS_I           (bus_i),
        .RESULT_BUS_O           (bus_o),
        .RESULT_BUS_OE          (bus_oe),
        .FIRST_CHANNEL_FLAG_O   (flag_o),
        .FIRST_CHANNEL_FLAG_OE  (flag_oe),
        .REF_SELECT             (ref_sel),
        .INTERNAL_REF_ENABLE    (ire)
    );
    arop_host arop_host_inst
    (
        .link_clk (link_clk),
        .bus_o    (bus_o),
        .bus_oe   (bus_oe),
        .flag_o   (flag_o),
        .cs_n     (cs_n),
        .rd_sclk  (rd_sclk)
    );
    initial
    begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    initial
    begin
        link_clk = 1'b0;
        #17;
        forever #62.5 link_clk = ~link_clk;
    end
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic results();
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // reset must span four link clocks as well, so it runs sixteen cycles, longer than twelve and a half
    task automatic rst_dut();
        @(negedge mclk) sys_rst = 1'b1;
        repeat (16) @(negedge mclk);
        sys_rst = 1'b0;
        arop_host_inst.waitl(5);
    endtask
    task automatic push(input logic [15:0] w, output logic acc);
        int t;
        t = 0;
        @(negedge mclk);
        res_valid = 1'b1;
        res_data = w;
        while (res_ready !== 1'b1 && t < 20)
        begin
            @(negedge mclk);
            t++;
        end
        acc = (res_ready === 1'b1);
        if (acc)
            @(posedge mclk);
    endtask
    initial
    begin
        #500000;
        fails++;
        results();
    end
    initial
    begin
        sys_rst = 1'b1;
        res_valid = 1'b0;
        res_data = 16'h0000;
        strap = 1'b0;
        ref_sel = 1'b1;
        tie = 16'h0000;
        repeat (16) @(negedge mclk);
        check("oe_in_reset", bus_oe, AROP_OE_NONE);
        check("flag_oe_in_reset", {15'h0000, flag_oe}, 16'h0000);
        check("ref_in_reset", {15'h0000, ire}, 16'h0000);
        foreach (rows[i])
        begin
            r = rows[i];
            @(negedge mclk);
            strap = r.strap;
            tie = {r.bms, r.hbf, 14'h0000};
            ref_sel = r.rsel;
            rst_dut();
            push(r.w0, ok);
            push(r.w1, ok);
            @(negedge mclk) res_valid = 1'b0;
            arop_host_inst.waitl(20);
            check("ref_enable", {15'h0000, ire}, {15'h0000, r.rsel});
            if (r.strap && !r.bms)
                arop_host_inst.frame(a, b, oe, f0, f1);
            else
            begin
                arop_host_inst.strobe(a, oe, f0);
                arop_host_inst.strobe(b, oe2, f1);
            end
            check("bus_enable", oe, r.oe);
            check("first_read", a, r.e0);
            check("second_read", b, r.e1);
            check("flag_first", {15'h0000, f0}, 16'h0001);
            check("flag_cleared", {15'h0000, f1}, 16'h0000);
            check("bus_released", bus_oe, AROP_OE_NONE);
        end
        @(negedge mclk);
        strap = 1'b0;
        tie = 16'h0000;
        rst_dut();
        push(16'hbeef, ok);
        @(negedge mclk) res_valid = 1'b0;
        arop_host_inst.waitl(20);
        arop_host_inst.hold(1'b0, 1'b0);
        arop_host_inst.waitl(6);
        check("word_mid_read", bus_o, 16'hbeef);
        check("flag_oe_in_read", {15'h0000, flag_oe}, 16'h0001);
        @(negedge mclk) sys_rst = 1'b1;
        repeat (16) @(negedge mclk);
        check("cleared_mid_read", bus_o, 16'h0000);
        sys_rst = 1'b0;
        arop_host_inst.hold(1'b1, 1'b1);
        arop_host_inst.waitl(6);
        // fill until the buffer refuses, then drain slowly in channel order
        rst_dut();
        n = 0;
        stall = 1'b0;
        for (int k = 0; k < 8; k++)
        begin
            if (!stall)
            begin
                push(16'h1100 + 16'(k), ok);
                if (ok)
                    n++;
                else
                    stall = 1'b1;
            end
        end
        @(negedge mclk) res_valid = 1'b0;
        check("stream_stall", {15'h0000, stall}, 16'h0001);
        arop_host_inst.waitl(20);
        for (int k = 0; k < n; k++)
        begin
            arop_host_inst.strobe(a, oe, f0);
            check("drain_order", a, 16'h1100 + 16'(k));
        end
        results();
    end
endmodule
`default_nettype wire
